/* File: src/wms_supervisor.v */
// Purpose: supervisor and mode dispatch for a angular_mode_a wheel controller
// Assumes: one 200 MHz clock, AHB-Lite slave, command values signed Q16.16
// Notes: control loops, converter and memory sit outside; this block steers them
`include "wms_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module wms_supervisor #(
    parameter FRAME_CYCLES = `WMS_FRAME_CYCLES
)
(
    input wire mclk_i,
    input wire rst_i,
    // ahb-lite slave
    input wire hsel_i,
    input wire [11:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output wire hreadyout_o,
    output wire hresp_o,
    output reg [31:0] hrdata_o,
    // events and system
    input wire [5:0] event_i,
    input wire conv_pulse_i,
    input wire wdog_service_i,
    input wire dram_multi_err_i,
    input wire pram_multi_err_i,
    input wire app_start_i,
    input wire [2:0] hall_code_i,
    input wire speed_zero_i,
    input wire [31:0] speed_i,
    input wire boot_mem_locked_i,
    input wire mem_done_i,
    // outputs
    output reg wdog_irq_o,
    output reg cpu_reset_o,
    output reg cpu_halt_o,
    output reg lockup_fault_o,
    output reg [7:0] diag_restart_mask_o,
    output reg comparators_inhibit_o,
    output reg [7:0] eff_mode_o,
    output reg [2:0] drive_kind_o,
    output reg drive_enable_o,
    output reg drive_reverse_o,
    output reg [31:0] drive_setpoint_o,
    output reg hall_override_o,
    output reg [2:0] hall_code_o,
    output reg [1:0] phase_sel_o,
    output reg phase_ground_en_o,
    output reg setpoint_div_rotor_moment_o,
    output reg [31:0] ramp_setpoint_o,
    output reg store_user_o,
    output reg store_boot_o,
    output reg erase_user_o
);
////////////////////////////////////////////////////////////////////////////////
// bus address phase capture
reg wr_pend_r;
reg [11:0] addr_r;
wire take = hsel_i && hready_i && htrans_i[1] && (hsize_i == 3'h2); // whole words only
wire wr_en = wr_pend_r;
assign hreadyout_o = 1'b1;
assign hresp_o = 1'b0;
// one data phase per address phase, zero wait
always @(posedge mclk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        wr_pend_r <= 1'b0;
        addr_r <= 12'h000;
    end
    else
    begin
        wr_pend_r <= take && hwrite_i;
        if (take)
            addr_r <= haddr_i;
    end
end
////////////////////////////////////////////////////////////////////////////////
// registers
reg [5:0] flags_r;
reg [7:0] rsten_r, rmask_r, mode_r;
reg [31:0] halt_r, lockup_r, cmd_r, frame_cnt_r;
reg [3:0] wdog_cnt_r;
reg [2:0] delay_r, hall_prev_r;
reg store_busy_r;
wire frame_tick = (frame_cnt_r == FRAME_CYCLES - 1);
wire hall_edge = (hall_code_i != hall_prev_r);
wire flags_wr = wr_en && (addr_r == `WMS_OFF_FLAGS);
// event flags: a hardware event wins over a software clear
genvar gi;
generate
    for (gi = 0; gi < `WMS_NFLAGS; gi = gi + 1)
    begin : g_flag
        always @(posedge mclk_i or posedge rst_i)
        begin
            if (rst_i)
                flags_r[gi] <= 1'b0;
            else if (event_i[gi] && !comparators_inhibit_o)
                flags_r[gi] <= 1'b1;
            else if (flags_wr)
                flags_r[gi] <= hwdata_i[gi];
        end
    end
endgenerate
// software registers
always @(posedge mclk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        rsten_r <= `WMS_RSTEN_RESET;
        halt_r <= 32'h00000000;
        lockup_r <= 32'h00000000;
        rmask_r <= 8'h00;
    end
    else if (wr_en)
    begin
        if (addr_r == `WMS_OFF_RSTEN)
            rsten_r <= {5'h00, hwdata_i[2:0]}; // bits 3-7 unused
        else if (addr_r == `WMS_OFF_HALT)
            halt_r <= hwdata_i;
        else if (addr_r == `WMS_OFF_LOCKUP)
            lockup_r <= hwdata_i;
        else if (addr_r == `WMS_OFF_RMASK)
            rmask_r <= hwdata_i[7:0];
    end
end
// mode and command; hardware clears win over software writes
always @(posedge mclk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        mode_r <= `WMS_M_IDLE;
        cmd_r <= 32'h00000000;
    end
    else
    begin
        if (wr_en && addr_r == `WMS_OFF_MODE)
            mode_r <= hwdata_i[7:0];
        if (store_busy_r && mem_done_i)
            cmd_r <= 32'h00000000;
        else if (mode_r == `WMS_M_RUNDOWN && cmd_r == `WMS_FX_ONE && speed_zero_i)
            cmd_r <= 32'h00000000;
        else if (mode_r == `WMS_M_STORE && cmd_r == `WMS_FX_TWO && boot_mem_locked_i)
            cmd_r <= 32'h00000000; // silent no-op
        else if (wr_en && addr_r == `WMS_OFF_CMD)
            cmd_r <= hwdata_i;
    end
end
////////////////////////////////////////////////////////////////////////////////
// watchdog, resets, halt, lockup
always @(posedge mclk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        wdog_cnt_r <= 4'h0;
        wdog_irq_o <= 1'b0;
        cpu_reset_o <= 1'b0;
        cpu_halt_o <= 1'b0;
        lockup_fault_o <= 1'b0;
        hall_prev_r <= 3'h0;
        diag_restart_mask_o <= 8'h00;
    end
    else
    begin
        // service clears; a pulse in the same cycle still counts from zero
        if (wdog_service_i)
            wdog_cnt_r <= {3'h0, conv_pulse_i};
        else if (conv_pulse_i && wdog_cnt_r != `WMS_WDOG_RST_COUNT)
            wdog_cnt_r <= wdog_cnt_r + 4'h1;
        wdog_irq_o <= (wdog_cnt_r >= `WMS_WDOG_IRQ_COUNT) && !wdog_service_i;
        cpu_reset_o <= (rsten_r[`WMS_RSTEN_WDOG] && wdog_cnt_r == `WMS_WDOG_RST_COUNT)
            || (rsten_r[`WMS_RSTEN_DRAM] && dram_multi_err_i)
            || (rsten_r[`WMS_RSTEN_PRAM] && pram_multi_err_i);
        cpu_halt_o <= (halt_r != 32'h00000000);
        hall_prev_r <= hall_code_i;
        if (lockup_r != 32'h00000000 && hall_edge)
            lockup_fault_o <= 1'b1;
        else if (lockup_r == 32'h00000000)
            lockup_fault_o <= 1'b0;
        diag_restart_mask_o <= rmask_r;
    end
end
////////////////////////////////////////////////////////////////////////////////
// control frame and startup delay
always @(posedge mclk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        frame_cnt_r <= 32'h00000000;
        delay_r <= `WMS_STARTUP_FRAMES;
    end
    else
    begin
        frame_cnt_r <= frame_tick ? 32'h00000000 : frame_cnt_r + 32'h00000001;
        if (app_start_i)
            delay_r <= `WMS_STARTUP_FRAMES;
        else if (frame_tick && delay_r != 3'h0)
            delay_r <= delay_r - 3'h1;
    end
end
////////////////////////////////////////////////////////////////////////////////
// mode dispatch; a restart forces idle in the same cycle as the inhibit flag
reg [7:0] em;
reg [2:0] kind, hcode;
reg en, ovr, divi;
always @*
begin
    em = (delay_r != 3'h0 || app_start_i) ? `WMS_M_IDLE : mode_r;
    kind = `WMS_DRV_OFF;
    en = 1'b0;
    ovr = 1'b0;
    hcode = hall_code_i;
    divi = 1'b0;
    if (em == `WMS_M_DUTY)
    begin
        kind = `WMS_DRV_DUTY;
        en = 1'b1;
    end
    else if (em == `WMS_M_VOLTS || em == `WMS_M_SIN_VOLTS)
    begin
        kind = (em == `WMS_M_VOLTS) ? `WMS_DRV_VOLTS : `WMS_DRV_SINE;
        en = 1'b1;
    end
    else if (em == `WMS_M_SPEED || em == `WMS_M_SIN_SPEED)
    begin
        kind = `WMS_DRV_SPEED;
        en = 1'b1;
    end
    else if (em >= `WMS_M_DUTY_H1 && em <= `WMS_M_DUTY_H6)
    begin
        kind = `WMS_DRV_DUTY;
        en = 1'b1;
        ovr = 1'b1;
        hcode = em[2:0] - 3'h3; // codes 4..9 wrap to 1..6
    end
    else if (em >= `WMS_M_VOLTS_H1 && em <= `WMS_M_VOLTS_H6)
    begin
        kind = `WMS_DRV_VOLTS;
        en = 1'b1;
        ovr = 1'b1;
        hcode = em[2:0] - 3'h1; // codes 10..15 give 1..6
    end
    else if (em == `WMS_M_RAMP || em == `WMS_M_TORQUE)
    begin
        kind = `WMS_DRV_RAMP;
        en = 1'b1;
        divi = (em == `WMS_M_TORQUE);
    end
    else if (em == `WMS_M_ANGULAR)
    begin
        kind = `WMS_DRV_SPEED;
        en = 1'b1;
        divi = 1'b1;
    end
    else if (em >= `WMS_M_PHASE0 && em <= `WMS_M_PHASE2)
    begin
        kind = `WMS_DRV_PHASE;
        en = 1'b1;
    end
    // idle, store, erase, rundown and undefined codes fall through, drive off
end
// memory requests issue once per command value; cleared value ends them
always @(posedge mclk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        store_busy_r <= 1'b0;
        store_user_o <= 1'b0;
        store_boot_o <= 1'b0;
        erase_user_o <= 1'b0;
    end
    else
    begin
        store_user_o <= 1'b0;
        store_boot_o <= 1'b0;
        erase_user_o <= 1'b0;
        if (store_busy_r)
        begin
            if (mem_done_i)
                store_busy_r <= 1'b0;
        end
        else if (delay_r == 3'h0 && mode_r == `WMS_M_STORE && cmd_r == `WMS_FX_ONE)
        begin
            store_user_o <= 1'b1;
            store_busy_r <= 1'b1;
        end
        else if (delay_r == 3'h0 && mode_r == `WMS_M_STORE && cmd_r == `WMS_FX_TWO
            && !boot_mem_locked_i)
        begin
            store_boot_o <= 1'b1;
            store_busy_r <= 1'b1;
        end
        else if (delay_r == 3'h0 && mode_r == `WMS_M_ERASE && cmd_r == `WMS_FX_ONE)
        begin
            erase_user_o <= 1'b1;
            store_busy_r <= 1'b1;
        end
    end
end
// registered drive outputs
always @(posedge mclk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        eff_mode_o <= `WMS_M_IDLE;
        drive_kind_o <= `WMS_DRV_OFF;
        drive_enable_o <= 1'b0;
        drive_reverse_o <= 1'b0;
        drive_setpoint_o <= 32'h00000000;
        hall_override_o <= 1'b0;
        hall_code_o <= 3'h0;
        phase_sel_o <= 2'h0;
        phase_ground_en_o <= 1'b0;
        setpoint_div_rotor_moment_o <= 1'b0;
        ramp_setpoint_o <= 32'h00000000;
        comparators_inhibit_o <= 1'b1;
    end
    else
    begin
        eff_mode_o <= em;
        drive_kind_o <= kind;
        drive_enable_o <= en;
        drive_reverse_o <= en && cmd_r[31]; // sign is direction
        drive_setpoint_o <= !en ? 32'h00000000 :
            (kind == `WMS_DRV_DUTY && cmd_r[31]) ? (~cmd_r + 32'h00000001) : cmd_r;
        hall_override_o <= ovr;
        hall_code_o <= hcode;
        phase_sel_o <= (kind == `WMS_DRV_PHASE) ? em[1:0] : 2'h0;
        phase_ground_en_o <= en && (kind != `WMS_DRV_PHASE);
        setpoint_div_rotor_moment_o <= divi;
        if (em != `WMS_M_RAMP)
            ramp_setpoint_o <= speed_i;
        else if (frame_tick)
            ramp_setpoint_o <= ramp_setpoint_o + cmd_r;
        comparators_inhibit_o <= (delay_r != 3'h0) || app_start_i;
    end
end
////////////////////////////////////////////////////////////////////////////////
// read mux
always @(posedge mclk_i or posedge rst_i)
begin
    if (rst_i)
        hrdata_o <= 32'h00000000;
    else if (take && !hwrite_i)
    begin
        if (haddr_i == `WMS_OFF_FLAGS)
            hrdata_o <= {26'h0000000, flags_r};
        else if (haddr_i == `WMS_OFF_RSTEN)
            hrdata_o <= {24'h000000, rsten_r};
        else if (haddr_i == `WMS_OFF_HALT)
            hrdata_o <= halt_r;
        else if (haddr_i == `WMS_OFF_LOCKUP)
            hrdata_o <= lockup_r;
        else if (haddr_i == `WMS_OFF_RMASK)
            hrdata_o <= {24'h000000, rmask_r};
        else if (haddr_i == `WMS_OFF_MODE)
            hrdata_o <= {24'h000000, mode_r};
        else if (haddr_i == `WMS_OFF_CMD)
            hrdata_o <= cmd_r;
        else if (haddr_i == `WMS_OFF_STATUS)
            hrdata_o <= {18'h00000, store_busy_r, lockup_fault_o, cpu_halt_o, delay_r, em};
        else if (haddr_i == `WMS_OFF_WDOG)
            hrdata_o <= {28'h0000000, wdog_cnt_r};
        else
            hrdata_o <= 32'h00000000; // unmapped reads zero
    end
end
endmodule
`default_nettype wire

/* File: inc/wms_consts.vh */
// Purpose: constants for the wheel mode supervisor
// Assumes: 32-bit AHB-Lite register bus, byte addresses
// Notes: offsets are word aligned
`ifndef WMS_CONSTS_VH
`define WMS_CONSTS_VH
// register byte offsets
`define WMS_OFF_FLAGS 12'h000
`define WMS_OFF_RSTEN 12'h004
`define WMS_OFF_HALT 12'h008
`define WMS_OFF_LOCKUP 12'h00C
`define WMS_OFF_RMASK 12'h010
`define WMS_OFF_MODE 12'h014
`define WMS_OFF_CMD 12'h018
`define WMS_OFF_STATUS 12'h01C
`define WMS_OFF_WDOG 12'h020
`define WMS_OFF_CTRL 12'h024
// flag bit positions
`define WMS_FLAG_HOT_WINDING 0
`define WMS_FLAG_COLD_PROC 1
`define WMS_FLAG_HOT_DRIVER 2
`define WMS_FLAG_TOO_FAST 3
`define WMS_FLAG_TOO_MUCH_CUR 4
`define WMS_FLAG_SENSOR 5
`define WMS_NFLAGS 6
// reset enable bits
`define WMS_RSTEN_WDOG 0
`define WMS_RSTEN_DRAM 1
`define WMS_RSTEN_PRAM 2
`define WMS_RSTEN_RESET 8'h00
// watchdog counts
`define WMS_WDOG_IRQ_COUNT 4'hA
`define WMS_WDOG_RST_COUNT 4'hF
// startup delay frames
`define WMS_STARTUP_FRAMES 3'h5
// control frame rate and clock
`define WMS_FRAME_HZ 100
`define WMS_CLK_HZ 200000000
`define WMS_FRAME_CYCLES (`WMS_CLK_HZ / `WMS_FRAME_HZ)
// mode codes
`define WMS_M_IDLE 8'h00
`define WMS_M_DUTY 8'h01
`define WMS_M_VOLTS 8'h02
`define WMS_M_SPEED 8'h03
`define WMS_M_DUTY_H1 8'h04
`define WMS_M_DUTY_H6 8'h09
`define WMS_M_VOLTS_H1 8'h0A
`define WMS_M_VOLTS_H6 8'h0F
`define WMS_M_RAMP 8'h10
`define WMS_M_ANGULAR 8'h11
`define WMS_M_TORQUE 8'h12
`define WMS_M_STORE 8'h16
`define WMS_M_ERASE 8'h17
`define WMS_M_PHASE0 8'h18
`define WMS_M_PHASE2 8'h1A
`define WMS_M_SIN_SPEED 8'h34
`define WMS_M_SIN_VOLTS 8'h35
`define WMS_M_RUNDOWN 8'h36
// fixed point command values, signed Q16.16
`define WMS_FX_ONE 32'h00010000
`define WMS_FX_TWO 32'h00020000
// drive kinds
`define WMS_DRV_OFF 3'h0
`define WMS_DRV_DUTY 3'h1
`define WMS_DRV_VOLTS 3'h2
`define WMS_DRV_SPEED 3'h3
`define WMS_DRV_RAMP 3'h4
`define WMS_DRV_PHASE 3'h5
`define WMS_DRV_SINE 3'h6
`endif

/* File: test/wms_supervisor_properties.sv */
// Purpose: port-level checker for wms_supervisor
// Assumes: FRAME_CYCLES equals the bound instance's value
// Notes: bound to every wms_supervisor instance
`timescale 1ns/10ps
`default_nettype none
module wms_supervisor_properties #(
    parameter FRAME_CYCLES = 20
)
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic app_start_i,
    input wire logic boot_mem_locked_i,
    input wire logic cpu_halt_o,
    input wire logic comparators_inhibit_o,
    input wire logic [7:0] eff_mode_o,
    input wire logic drive_enable_o,
    input wire logic [2:0] drive_kind_o,
    input wire logic hall_override_o,
    input wire logic [2:0] hall_code_o,
    input wire logic phase_ground_en_o,
    input wire logic store_user_o,
    input wire logic store_boot_o,
    input wire logic erase_user_o
);
default clocking cb @(posedge mclk_i);
endclocking
default disable iff (rst_i);
////////////////////////////////////////////////////////////////////////
// length of the idle spell; a restart opens a fresh one
logic [31:0] inh_r;
always_ff @(posedge mclk_i or posedge rst_i)
begin
    if (rst_i)
        inh_r <= 32'h0;
    else if (app_start_i || !comparators_inhibit_o)
        inh_r <= 32'h0;
    else
        inh_r <= inh_r + 32'h1;
end
// a one-shot store with the drive off, gone the next cycle
sequence s_user_shot;
    store_user_o && !drive_enable_o ##1 !store_user_o;
endsequence
////////////////////////////////////////////////////////////////////////
chk_delay_idle: assert property (comparators_inhibit_o |-> eff_mode_o == 8'h00 && !drive_enable_o)
    else $error("drive active during startup delay");
chk_delay_len: assert property (inh_r <= 5 * FRAME_CYCLES + 8)
    else $error("startup delay longer than five frames");
chk_idle_off: assert property (eff_mode_o == 8'h00 |-> !drive_enable_o)
    else $error("drive on in idle");
chk_phase_float: assert property (drive_kind_o == 3'h5 |-> !phase_ground_en_o)
    else $error("phase grounded in single-phase mode");
chk_forced_code: assert property (hall_override_o |-> hall_code_o != 3'h0 && hall_code_o != 3'h7)
    else $error("forced sensor code out of range");
chk_user_shot: assert property ($rose(store_user_o) |-> s_user_shot)
    else $error("user store not a single pulse with drive off");
chk_locked_boot: assert property ($past(boot_mem_locked_i) |-> !store_boot_o)
    else $error("store to locked boot memory");
chk_erase_shot: assert property (erase_user_o |=> !erase_user_o && !drive_enable_o)
    else $error("erase not a single pulse");
chk_halt_hold: assert property (cpu_halt_o |=> cpu_halt_o)
    else $error("halt released");
endmodule
bind wms_supervisor wms_supervisor_properties #(.FRAME_CYCLES(FRAME_CYCLES)) u_chk (
    .mclk_i(mclk_i), .rst_i(rst_i), .app_start_i(app_start_i), .boot_mem_locked_i(boot_mem_locked_i),
    .cpu_halt_o(cpu_halt_o), .comparators_inhibit_o(comparators_inhibit_o), .eff_mode_o(eff_mode_o),
    .drive_enable_o(drive_enable_o), .drive_kind_o(drive_kind_o), .hall_override_o(hall_override_o),
    .hall_code_o(hall_code_o), .phase_ground_en_o(phase_ground_en_o), .store_user_o(store_user_o),
    .store_boot_o(store_boot_o), .erase_user_o(erase_user_o));
`default_nettype wire

/* File: test/wms_host_model.sv */
// Purpose: ahb-lite host issuing single word transfers
// Assumes: one slave, its hreadyout is hready
// Notes: waits on hready without assuming a latency
`timescale 1ns/10ps
`default_nettype none
module wms_host_model
(
    input wire logic mclk_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    output logic hsel_o,
    output logic [11:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [2:0] hsize_o,
    output logic [31:0] hwdata_o
);
// bus quiet at time zero, word size only
initial
begin
    hsel_o = 1'b0;
    haddr_o = 12'h000;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = 3'h2;
    hwdata_o = 32'h0;
end
////////////////////////////////////////////////////////////////////////
// address phase held until hready, then data phase; read data taken there
task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk_i);
    hsel_o <= 1'b1;
    haddr_o <= a;
    hwrite_o <= w;
    htrans_o <= 2'h2;
    do @(posedge mclk_i); while (hready_i !== 1'b1);
    htrans_o <= 2'h0;
    hwdata_o <= d;
    do @(posedge mclk_i); while (hready_i !== 1'b1);
    q = hrdata_i;
endtask
endmodule
`default_nettype wire

/* File: test/test_wms_supervisor.sv */
// Purpose: self-checking bench for wms_supervisor
// Assumes: frames shortened to FC cycles
// Notes: memory answers one cycle after each request
`include "wms_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module test_wms_supervisor;
localparam int FC = 20;
logic mclk_i = 0, rst_i = 1, conv = 0, svc = 0, dram = 0, pram = 0, start = 0, zero = 0, lock = 0, done = 0;
logic [5:0] ev = 6'h00;
logic [2:0] hall = 3'h1;
logic hsel, hwrite, hrdy, hresp, irq, crst, halt, lockf, inh, den, drev, hov, pgnd, sdiv, su, sb, eu;
logic [11:0] haddr;
logic [1:0] htrans, psel;
logic [2:0] hsize, dkind, hcode;
logic [31:0] hwdata, hrdata, dset, ramp, q, a;
logic [31:0] spd = 32'h00030000;
logic [7:0] rmask, emode;
logic [7:0] md [0:13] = '{8'h00, 8'h02, 8'h03, 8'h10, 8'h11, 8'h12, 8'h16, 8'h17, 8'h18, 8'h20,
    8'h19, 8'h1A, 8'h35, 8'h36};
logic [2:0] kd [0:13] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h3, 3'h4, 3'h0, 3'h0, 3'h5, 3'h0, 3'h5, 3'h5, 3'h6, 3'h0};
int n_errors = 0, n_checks = 0, n_user = 0, n_boot = 0, n_erase = 0, i;
////////////////////////////////////////////////////////////////////////
wms_supervisor #(.FRAME_CYCLES(FC)) u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy),
    .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata), .event_i(ev), .conv_pulse_i(conv),
    .wdog_service_i(svc), .dram_multi_err_i(dram), .pram_multi_err_i(pram), .app_start_i(start),
    .hall_code_i(hall), .speed_zero_i(zero), .speed_i(spd), .boot_mem_locked_i(lock),
    .mem_done_i(done), .wdog_irq_o(irq), .cpu_reset_o(crst), .cpu_halt_o(halt), .lockup_fault_o(lockf),
    .diag_restart_mask_o(rmask), .comparators_inhibit_o(inh), .eff_mode_o(emode), .drive_kind_o(dkind),
    .drive_enable_o(den), .drive_reverse_o(drev), .drive_setpoint_o(dset), .hall_override_o(hov),
    .hall_code_o(hcode), .phase_sel_o(psel), .phase_ground_en_o(pgnd), .setpoint_div_rotor_moment_o(sdiv),
    .ramp_setpoint_o(ramp), .store_user_o(su), .store_boot_o(sb), .erase_user_o(eu));
wms_host_model u_host (.mclk_i(mclk_i), .hready_i(hrdy), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));
// 200 MHz clock
initial forever #2.5 mclk_i = ~mclk_i;
// memory finishes one cycle after each one-shot; one-shots counted as seen
always @(posedge mclk_i)
begin
    done <= (su === 1'b1) | (sb === 1'b1) | (eu === 1'b1);
    n_user <= n_user + (su === 1'b1);
    n_boot <= n_boot + (sb === 1'b1);
    n_erase <= n_erase + (eu === 1'b1);
end
////////////////////////////////////////////////////////////////////////
task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
        n_errors++;
        $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
endtask
task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    u_host.xfer(1'b1, ad, d, q);
endtask
task automatic rd(input logic [11:0] ad, input logic [31:0] e);
    u_host.xfer(1'b0, ad, 32'h0, q);
    cmp(q, e);
endtask
// ends on a falling edge so outputs have settled
task automatic nap(input int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
endtask
// idle first so the store and erase modes are entered with the new value
task automatic cmd_mode(input logic [31:0] c, input logic [7:0] m);
    wr(`WMS_OFF_MODE, 32'h0);
    wr(`WMS_OFF_CMD, c);
    wr(`WMS_OFF_MODE, {24'h0, m});
    nap(FC + 8);
endtask
task automatic cpulse(input int n);
    repeat (n)
    begin
        @(posedge mclk_i);
        conv <= 1'b1;
        @(posedge mclk_i);
        conv <= 1'b0;
    end
endtask
task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////
// a hang is cut short well past the expected run
initial
begin
    #60000;
    n_errors++;
    tally_and_finish();
end
initial
begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    wr(`WMS_OFF_MODE, {24'h0, `WMS_M_DUTY});
    wr(`WMS_OFF_CMD, 32'hFFFF0000);
    nap(3);
    cmp(emode, 8'h00);
    cmp(inh, 1'b1);
    nap(6 * FC);
    cmp(inh, 1'b0);
    cmp({dkind, den, drev}, {`WMS_DRV_DUTY, 2'b11});
    cmp(dset, `WMS_FX_ONE);
    cmp(ramp, 32'h00030000);
    @(posedge mclk_i);
    start <= 1'b1;
    @(posedge mclk_i);
    start <= 1'b0;
    nap(3);
    cmp({inh, emode}, 9'h100);
    // an event while inhibited must leave its flag clear
    @(posedge mclk_i);
    ev <= 6'h01;
    @(posedge mclk_i);
    ev <= 6'h00;
    rd(`WMS_OFF_FLAGS, 32'h0);
    nap(6 * FC);
    cmp(emode, `WMS_M_DUTY);
    $display("test startup done");
    wr(`WMS_OFF_FLAGS, 32'h3F);
    cmp({hresp, hrdy}, 2'b01);
    rd(`WMS_OFF_FLAGS, 32'h3F);
    wr(`WMS_OFF_FLAGS, 32'h0);
    rd(`WMS_OFF_FLAGS, 32'h0);
    @(posedge mclk_i);
    ev <= 6'h08;
    @(posedge mclk_i);
    ev <= 6'h00;
    rd(`WMS_OFF_FLAGS, 32'h08);
    wr(`WMS_OFF_RSTEN, 32'hFF);
    rd(`WMS_OFF_RSTEN, 32'h07);
    rd(12'h0FC, 32'h0);
    wr(`WMS_OFF_RMASK, 32'h5A);
    nap(3);
    cmp(rmask, 8'h5A);
    $display("test registers done");
    wr(`WMS_OFF_CMD, 32'h0);
    for (i = 0; i < 14; i++)
    begin
        wr(`WMS_OFF_MODE, {24'h0, md[i]});
        nap(FC + 3);
        cmp({dkind, den}, {kd[i], kd[i] != 3'h0});
        cmp(sdiv, md[i] == 8'h11 || md[i] == 8'h12);
        cmp({psel, pgnd}, {((kd[i] == 3'h5) ? 2'(md[i] - 8'h18) : 2'h0), kd[i] != 3'h0 && kd[i] != 3'h5});
    end
    for (i = 4; i < 16; i++)
    begin
        wr(`WMS_OFF_MODE, i);
        nap(FC + 3);
        cmp({hov, hcode, dkind}, {1'b1, 3'((i - 4) % 6 + 1), i < 10 ? `WMS_DRV_DUTY : `WMS_DRV_VOLTS});
    end
    // outside the ramp mode the target follows a new speed
    @(posedge mclk_i);
    spd <= 32'h00050000;
    nap(2);
    cmp(ramp, 32'h00050000);
    cmd_mode(`WMS_FX_ONE, `WMS_M_RAMP);
    a = ramp;
    nap(FC);
    cmp(ramp - a, `WMS_FX_ONE);
    $display("test modes done");
    cmd_mode(`WMS_FX_ONE, `WMS_M_STORE);
    cmp(n_user, 1);
    rd(`WMS_OFF_CMD, 32'h0);
    cmd_mode(`WMS_FX_TWO, `WMS_M_STORE);
    cmp(n_boot, 1);
    @(posedge mclk_i);
    lock <= 1'b1;
    cmd_mode(`WMS_FX_TWO, `WMS_M_STORE);
    cmp(n_boot, 1);
    rd(`WMS_OFF_CMD, 32'h0);
    cmd_mode(`WMS_FX_ONE, `WMS_M_ERASE);
    cmp(n_erase, 1);
    rd(`WMS_OFF_CMD, 32'h0);
    cmd_mode(`WMS_FX_ONE, `WMS_M_RUNDOWN);
    rd(`WMS_OFF_CMD, `WMS_FX_ONE);
    zero <= 1'b1;
    nap(FC + 3);
    rd(`WMS_OFF_CMD, 32'h0);
    $display("test memory done");
    wr(`WMS_OFF_RSTEN, 32'h0);
    dram <= 1'b1;
    pram <= 1'b1;
    nap(5);
    cmp(crst, 1'b0);
    wr(`WMS_OFF_RSTEN, 32'h2);
    nap(3);
    cmp(crst, 1'b1);
    @(posedge mclk_i);
    dram <= 1'b0;
    nap(3);
    cmp(crst, 1'b0);
    wr(`WMS_OFF_RSTEN, 32'h4);
    nap(3);
    cmp(crst, 1'b1);
    @(posedge mclk_i);
    pram <= 1'b0;
    wr(`WMS_OFF_RSTEN, 32'h1);
    cpulse(9);
    nap(3);
    cmp(irq, 1'b0);
    cpulse(1);
    nap(3);
    cmp(irq, 1'b1);
    @(posedge mclk_i);
    svc <= 1'b1;
    @(posedge mclk_i);
    svc <= 1'b0;
    rd(`WMS_OFF_WDOG, 32'h0);
    cpulse(14);
    nap(3);
    cmp(crst, 1'b0);
    cpulse(1);
    nap(3);
    cmp(crst, 1'b1);
    $display("test watchdog done");
    wr(`WMS_OFF_LOCKUP, 32'h1);
    nap(3);
    cmp(lockf, 1'b0);
    @(posedge mclk_i);
    hall <= 3'h3;
    nap(3);
    cmp(lockf, 1'b1);
    wr(`WMS_OFF_HALT, 32'h2);
    nap(3);
    cmp(halt, 1'b1);
    rd(`WMS_OFF_STATUS, 32'h00001836);
    $display("test faults done");
    tally_and_finish();
end
endmodule
`default_nettype wire
